// file: pold_pkg.sv
// Package for the PCM output line decoder: codes and constants
package pold_pkg;

  // ****************************************
  // Line code selections
  // ****************************************
  typedef enum logic [3:0] {
    CODE_NRZL,
    CODE_NRZM,
    CODE_NRZS,
    CODE_RZ,
    CODE_BIPL,
    CODE_BIPM,
    CODE_BIPS,
    CODE_DMM,
    CODE_DMS,
    CODE_M2M,
    CODE_M2S
  } pold_code_e;

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic POLD_LEVEL_RST = 1'b0;
  localparam int POLD_BUF_DEPTH = 2;
  localparam int POLD_CLK_DIV_MIN = 2;

endpackage

// file: pold_stream_if.sv
// Interface carrying decoded bits between decoder core and output buffer
`timescale 1ns/10ps
`default_nettype none
interface pold_stream_if;
  logic valid;
  logic ready;
  logic data;

  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: pold_buf.sv
// Two-entry skid buffer for decoded output bits
`timescale 1ns/10ps
`default_nettype none
module pold_buf
  import pold_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Fill side
  pold_stream_if.sink inS,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic outData
);

  logic [WIDTH-1:0] mem_q [POLD_BUF_DEPTH];
  logic wrPtr_q;
  logic rdPtr_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  assign inS.ready = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign outData = mem_q[rdPtr_q][0];
  assign push = inS.valid && inS.ready;
  assign pop = outValid && outReady;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
    end
    else
    begin
      if (push)
        wrPtr_q <= ~wrPtr_q;
      if (pop)
        rdPtr_q <= ~rdPtr_q;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wrPtr_q] <= WIDTH'(inS.data);
  end

endmodule
`default_nettype wire

// file: pold_top.sv
// PCM output line decoder: line code to NRZ-L conversion or pass-through
//
// Function
// - A selected source code is decoded to NRZ-L at the data output.
// - A pass-through setting sends symbols out exactly as received.
// - In pass-through one output clock is given per received symbol.
// - Miller-squared and delay modulation, mark and space, are separate codes.
`timescale 1ns/10ps
`default_nettype none
module pold_top
  import pold_pkg::*;
#(
  parameter int CLK_DIV = 4
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Configuration
  input wire logic [3:0] codeSel,
  // Symbol input from demodulator
  input wire logic symValid,
  input wire logic symData,
  output logic symReady,
  // PCM output toward recorder
  output logic pcmData,
  output logic pcmClk,
  output logic pcmValid
);

  // ****************************************
  // Code classification
  // ****************************************
  pold_code_e code;
  logic twoSym;
  logic sinkReady;
  assign code = pold_code_e'(codeSel);
  // Codes 11 to 15 fall through to NRZ-L handling
  // Two-symbol codes decode over a pair of symbols
  // separate families
  assign twoSym = (code == CODE_RZ) || (code == CODE_BIPL) ||
    (code == CODE_BIPM) || (code == CODE_BIPS) || (code == CODE_DMM) ||
    (code == CODE_DMS) || (code == CODE_M2M) || (code == CODE_M2S);

  pold_stream_if bitS();

  // ****************************************
  // Symbol pairing and decode
  // ****************************************
  // Set while the first symbol of a pair is held
  logic half_q;
  logic first_q;
  logic prevSym_q;
  logic outValid_q;
  logic outBit_q;
  logic take;
  logic decBit;
  logic emit;
  logic symReady_d;

  assign take = symValid && symReady;
  // A bit leaves on every symbol, or on the second of a pair
  assign emit = take && (!twoSym || half_q);

  always_comb
  begin
    // Default keeps the symbol so unlisted codes pass it
    decBit = symData;
    case (code)
      CODE_NRZL: decBit = symData;
      CODE_NRZM: decBit = symData ^ prevSym_q;
      CODE_NRZS: decBit = ~(symData ^ prevSym_q);
      // RZ and biphase-L carry the bit in the first half
      CODE_RZ: decBit = first_q;
      CODE_BIPL: decBit = first_q;
      CODE_BIPM: decBit = first_q ^ symData;
      CODE_BIPS: decBit = ~(first_q ^ symData);
      CODE_DMM: decBit = first_q ^ symData;
      CODE_DMS: decBit = ~(first_q ^ symData);
      // Miller-squared pair
      // Read from the mid-bit transition, as for delay modulation
      CODE_M2M: decBit = first_q ^ symData;
      CODE_M2S: decBit = ~(first_q ^ symData);
      default: decBit = symData;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      half_q <= 1'b0;
      first_q <= POLD_LEVEL_RST;
      prevSym_q <= POLD_LEVEL_RST;
    end
    else if (take)
    begin
      // pair symbols per bit
      // Pairing is not realigned on a code change; reset realigns it
      half_q <= twoSym ? ~half_q : 1'b0;
      first_q <= symData;
      prevSym_q <= symData;
    end
  end

  // ****************************************
  // Decoded bit register
  // ****************************************
  // Holds one decoded bit until the buffer takes it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      outValid_q <= 1'b0;
      outBit_q <= POLD_LEVEL_RST;
    end
    else
    begin
      if (outValid_q && bitS.ready)
        outValid_q <= 1'b0;
      if (emit)
      begin
        outValid_q <= 1'b1;
        outBit_q <= decBit;
      end
    end
  end

  assign bitS.valid = outValid_q;
  assign bitS.data = outBit_q;

  // ****************************************
  // Symbol ready register
  // ****************************************
  // Ready opens only when the decode register is empty next cycle
  // One symbol slot is lost after each bit; the output period, at least two cycles, is no shorter
  assign symReady_d = !(emit || (outValid_q && !bitS.ready));

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      symReady <= 1'b1;
    else
      symReady <= symReady_d;
  end

  // ****************************************
  // Output buffer
  // ****************************************
  // Skid buffer drained one bit per output period by the divider below
  logic bufValid;
  logic bufData;

  pold_buf #(
    .WIDTH(1)
  ) uBuf (
    .clk(clk),
    .nrst(nrst),
    .inS(bitS),
    .outValid(bufValid),
    .outReady(sinkReady),
    .outData(bufData)
  );

  // ****************************************
  // Output clock divider
  // ****************************************
  // Below two cycles the clock could not rise inside its bit
  localparam int DIV = (CLK_DIV < POLD_CLK_DIV_MIN) ? POLD_CLK_DIV_MIN
    : CLK_DIV;
  localparam logic [15:0] DIV_LOAD = 16'(DIV - 1);
  localparam logic [15:0] DIV_HALF = 16'(DIV / 2);
  logic [15:0] divCnt_q;

  // one clock per decoded bit
  // Bits load only at period end, so data holds while the clock is high
  assign sinkReady = bufValid && (divCnt_q == 16'h0000);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      divCnt_q <= 16'h0000;
      pcmData <= POLD_LEVEL_RST;
      pcmValid <= 1'b0;
      pcmClk <= 1'b0;
    end
    else
    begin
      if (sinkReady)
      begin
        pcmData <= bufData;
        pcmValid <= 1'b1;
        pcmClk <= 1'b0;
        divCnt_q <= DIV_LOAD;
      end
      else if (divCnt_q != 16'h0000)
      begin
        divCnt_q <= divCnt_q - 16'h0001;
        // Clock rises half a period after the data
        if (divCnt_q == DIV_HALF)
          pcmClk <= 1'b1;
      end
      else
      begin
        // Idle: clock and valid stand low between bits
        pcmClk <= 1'b0;
        pcmValid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// file: pold_top_properties.sv
// Port checker for the PCM output line decoder
`timescale 1ns/10ps
`default_nettype none
module pold_top_properties
  import pold_pkg::*;
#(
  parameter int CLK_DIV = 4
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Watched ports
  input wire logic [3:0] codeSel,
  input wire logic symValid,
  input wire logic symData,
  input wire logic symReady,
  input wire logic pcmData,
  input wire logic pcmClk,
  input wire logic pcmValid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_taken_gives_bit: assert property (symValid && symReady &&
    codeSel == CODE_NRZL |-> ##[1:60] pcmValid) else $error("no bit out");
  a_data_held_high: assert property (pcmClk
    |-> $stable(pcmData)) else $error("data moved under clock");
  a_clk_in_bit: assert property (pcmClk |-> pcmValid)
    else $error("clock outside bit");
  a_clk_mid_first: assert property ($rose(pcmValid)
    |-> !pcmClk ##[1:8] pcmClk) else $error("first bit lacks clock");
  a_clk_each_bit: assert property ($fell(pcmClk) && pcmValid
    |-> ##[1:8] pcmClk) else $error("bit lacks clock");
endmodule
bind pold_top pold_top_properties #(.CLK_DIV(CLK_DIV)) u_props (
  .clk(clk),
  .nrst(nrst),
  .codeSel(codeSel),
  .symValid(symValid),
  .symData(symData),
  .symReady(symReady),
  .pcmData(pcmData),
  .pcmClk(pcmClk),
  .pcmValid(pcmValid)
);
`default_nettype wire

// file: pold_sink_model.sv
// Downstream recorder model sampling data on the output clock
`timescale 1ns/10ps
`default_nettype none
module pold_sink_model
(
  // Clock
  input wire logic clk,
  // PCM lines
  input wire logic pcmClk,
  input wire logic pcmData,
  // Sampled bit
  output logic got,
  output logic bitSeen
);
  logic pcmClk_q;
  always_ff @(posedge clk)
  begin
    pcmClk_q <= pcmClk;
    got <= pcmClk && !pcmClk_q;
    bitSeen <= pcmData;
  end
endmodule
`default_nettype wire

// file: pold_top_tb.sv
// Testbench for the PCM output line decoder
`timescale 1ns/10ps
`default_nettype none
module pold_top_tb;
  import pold_pkg::*;
  logic clk = 0, nrst = 0, symValid = 0, symData = 0, stall = 0;
  logic [3:0] codeSel = 4'h0;
  logic symReady, pcmData, pcmClk, pcmValid, got, bitSeen, ok, prv, f, bt;
  logic s2;
  logic q[$];
  int fails = 0, tests_run = 0;
  always #2.5 clk = ~clk;
  pold_top #(.CLK_DIV(2)) u_dut (.clk(clk), .nrst(nrst),
    .codeSel(codeSel), .symValid(symValid), .symData(symData),
    .symReady(symReady), .pcmData(pcmData), .pcmClk(pcmClk),
    .pcmValid(pcmValid));
  pold_sink_model u_sink (.clk(clk), .pcmClk(pcmClk),
    .pcmData(pcmData), .got(got), .bitSeen(bitSeen));
  task automatic chk(string n, logic e, logic s);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected %s: expected %b, seen %b", n, e, s);
    end
  endtask
  task automatic send(logic s);
    symValid = 1;
    symData = s;
    do
    begin
      #1 ok = symReady;
      @(posedge clk);
      #1;
    end while (!ok);
  endtask
  task automatic give_verdict();
    $display("%0d compares, %0d mismatches", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    if (symValid && !symReady)
      stall = 1;
    if (got)
      chk("pcmData", q.size() ? q.pop_front() : !bitSeen, bitSeen);
  end
  initial
  begin
    void'($urandom(1));
    repeat (8) @(posedge clk);
    for (int c = 0; c < 12; c++)
    begin
      #1 nrst = 0;
      // pass-through of a two-symbol stream in the last pass
      codeSel = (c == 11) ? 4'h0 : c[3:0];
      prv = 0;
      @(posedge clk);
      #1 nrst = 1;
      repeat (16)
      begin
        bt = 1'($urandom);
        if (c < 3)
        begin
          prv = c ? prv ^ bt ^ (c == 2) : bt;
          q.push_back(bt);
          send(prv);
        end
        else
        begin
          f = c < 5 ? bt : 1'($urandom);
          s2 = c == 3 ? 1'b0 : c == 4 ? !bt : f ^ bt ^ !c[0];
          q.push_back(c == 11 ? f : bt);
          if (c == 11)
            q.push_back(s2);
          send(f);
          send(s2);
        end
      end
      symValid = 0;
      repeat (40) @(posedge clk);
      chk("drained", 1'b1, q.size() == 0);
      $display("code %0d done", c);
    end
    chk("refused", 1'b1, stall);
    give_verdict();
  end
  initial
  begin
    #20000;
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire
